/* rtl/port_power_fault_status_regs.sv */
// power condition and fault condition report registers of the port
//
// Overview of operation
// - device owns power report, host reads after alert
// - bit 7 shows debug accessory attached
// - bit 6 high while initialization runs
// - bit 5 shows raised voltage while sourcing
// - bit 4 shows bus power being sourced
// - bit 3 bus detect enabled, resets high
// - bit 2 shows bus at least 4V
// - bit 1 cable power on either pin
// - bit 0 sinking always reads zero
// - device sets fault flags, host clears them
// - fault bits ordered reset down to bus error
// - registers-reset flag set by every reset
`include "tcpc_status_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module port_power_fault_status_regs (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire tcpc_status_pkg::reg_req_t reg_req,
  input wire tcpc_status_pkg::ctrl_status_t ctrl,
  input wire tcpc_status_pkg::analog_in_t analog,
  input wire logic i2c_error,
  output logic [`REG_DATA_W-1:0] rd_data_q,
  output logic rd_valid_q,
  output logic [`REG_DATA_W-1:0] power_report_q,
  output logic [`REG_DATA_W-1:0] fault_report_q,
  output logic power_changed_q,
  output logic fault_pending_q
);

  // --------------------------------------------------------------------
  // reset release
  // --------------------------------------------------------------------
  // release kept outside the clock enable so a frozen block still leaves
  // reset cleanly
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // --------------------------------------------------------------------
  // comparator synchronisers
  // --------------------------------------------------------------------
  tcpc_status_pkg::analog_in_t meta_q, meta_d;
  tcpc_status_pkg::analog_in_t sync_q, sync_d;

  always_comb begin
    meta_d = analog;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (ce) begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  // --------------------------------------------------------------------
  // power condition report
  // --------------------------------------------------------------------
  logic [`REG_DATA_W-1:0] power_report_d;
  logic power_changed_d;

  // only live levels feed this register, so the host bus has no path in
  always_comb begin
    power_report_d = '0;
    power_report_d[`PWR_DEBUG_BIT] = ctrl.debug_accessory_attached;
    power_report_d[`PWR_INIT_BIT] = ctrl.init_running;
    // gated so the field never claims a raised level while idle
    power_report_d[`PWR_RAISED_BIT] =
      ctrl.sourcing_raised_voltage & ctrl.sourcing_bus_power;
    power_report_d[`PWR_SOURCING_BIT] = ctrl.sourcing_bus_power;
    power_report_d[`PWR_DETECT_BIT] = ctrl.bus_detect_enabled;
    power_report_d[`PWR_BUS_PRESENT_BIT] = sync_q.bus_power_present;
    power_report_d[`PWR_CABLE_BIT] =
      sync_q.cc1_cable_power | sync_q.cc2_cable_power;
    power_report_d[`PWR_SINKING_BIT] = 1'b0;
    power_changed_d = power_report_d != power_report_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_report_q <= `PWR_RESET;
      power_changed_q <= 1'b0;
    end else if (ce) begin
      power_report_q <= power_report_d;
      power_changed_q <= power_changed_d;
    end
  end

  // --------------------------------------------------------------------
  // fault condition report
  // --------------------------------------------------------------------
  logic [`REG_DATA_W-1:0] fault_set;
  logic [`REG_DATA_W-1:0] fault_clr;
  logic fault_pending_d;

  always_comb begin
    fault_set = '0;
    // registers-reset comes only from the reset value of the bank
    fault_set[`FLT_REGS_RESET_BIT] = 1'b0;
    fault_set[`FLT_FORCED_OFF_BIT] = sync_q.bus_forced_off;
    fault_set[`FLT_AUTO_DISCH_BIT] = sync_q.auto_discharge_failed;
    fault_set[`FLT_FORCED_DISCH_BIT] = sync_q.forced_discharge_failed;
    fault_set[`FLT_BUS_OC_BIT] = sync_q.bus_overcurrent;
    fault_set[`FLT_BUS_OV_BIT] = sync_q.bus_overvoltage;
    fault_set[`FLT_CABLE_OC_BIT] = sync_q.cable_power_overcurrent;
    fault_set[`FLT_I2C_ERR_BIT] = i2c_error;
    fault_clr = '0;
    if (reg_req.wr && reg_req.addr == `FLT_REPORT_OFFSET) begin
      fault_clr = reg_req.wdata;
    end
    fault_pending_d = |fault_report_q;
  end

  sticky_flag_bank #(
    .W(`REG_DATA_W),
    .RESET_VAL(`FLT_RESET)
  ) u_fault_flags (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .set(fault_set),
    .clr(fault_clr),
    .flags_q(fault_report_q)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_pending_q <= 1'b0;
    end else if (ce) begin
      fault_pending_q <= fault_pending_d;
    end
  end

  // --------------------------------------------------------------------
  // read port
  // --------------------------------------------------------------------
  logic [`REG_DATA_W-1:0] rd_data_d;
  logic rd_valid_d;

  always_comb begin
    rd_valid_d = reg_req.rd;
    rd_data_d = rd_data_q;
    if (reg_req.rd) begin
      if (reg_req.addr == `PWR_REPORT_OFFSET) begin
        rd_data_d = power_report_q;
      end else if (reg_req.addr == `FLT_REPORT_OFFSET) begin
        rd_data_d = fault_report_q;
      end else begin
        rd_data_d = `UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= '0;
      rd_valid_q <= 1'b0;
    end else if (ce) begin
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_sink_always_zero: assert property (
    !power_report_q[`PWR_SINKING_BIT])
    else $error("sinking bit not zero");
  // the edge that lifts rst_n still loads reset values, so the follow
  // checks start only from an edge that sampled the block out of reset
  a_debug_follows: assert property (
    rst_n && ce |=> power_report_q[`PWR_DEBUG_BIT] ==
      $past(ctrl.debug_accessory_attached))
    else $error("debug bit wrong");
  a_init_follows: assert property (
    rst_n && ce |=> power_report_q[`PWR_INIT_BIT] ==
      $past(ctrl.init_running))
    else $error("init bit wrong");
  a_raised_needs_source: assert property (
    power_report_q[`PWR_RAISED_BIT] |-> power_report_q[`PWR_SOURCING_BIT])
    else $error("raised voltage without sourcing");
  a_source_follows: assert property (
    rst_n && ce |=> power_report_q[`PWR_SOURCING_BIT] ==
      $past(ctrl.sourcing_bus_power))
    else $error("sourcing bit wrong");
  a_detect_follows: assert property (
    rst_n && ce |=> power_report_q[`PWR_DETECT_BIT] ==
      $past(ctrl.bus_detect_enabled))
    else $error("detect bit wrong");
  a_bus_present_seen: assert property (
    (ce && analog.bus_power_present)[*3] |=>
      power_report_q[`PWR_BUS_PRESENT_BIT])
    else $error("bus present not reported in 3 cycles");
  a_cable_power_seen: assert property (
    (ce && analog.cc2_cable_power)[*3] |=> power_report_q[`PWR_CABLE_BIT])
    else $error("cable power not reported in 3 cycles");
  a_fault_set_wins: assert property (
    ce && i2c_error |=> fault_report_q[`FLT_I2C_ERR_BIT])
    else $error("i2c error flag not set");
  a_fault_sticky: assert property (
    ce && fault_report_q[`FLT_BUS_OC_BIT] && !fault_clr[`FLT_BUS_OC_BIT]
      |=> fault_report_q[`FLT_BUS_OC_BIT])
    else $error("fault flag dropped without clear");
  a_regs_reset_flag: assert property (
    $rose(rst_n) |-> fault_report_q[`FLT_REGS_RESET_BIT])
    else $error("registers-reset flag not set after reset");
  a_power_read_data: assert property (
    ce && reg_req.rd && reg_req.addr == `PWR_REPORT_OFFSET |=>
      rd_valid_q && rd_data_q == $past(power_report_q))
    else $error("power report read wrong");

  c_fault_cleared: cover property (
    ce && fault_report_q[`FLT_I2C_ERR_BIT] && fault_clr[`FLT_I2C_ERR_BIT]
      && !i2c_error ##1 !fault_report_q[`FLT_I2C_ERR_BIT]);
  c_set_during_clear: cover property (
    ce && i2c_error && fault_clr[`FLT_I2C_ERR_BIT]);
  c_read_while_sourcing: cover property (
    ce && reg_req.rd && reg_req.addr == `PWR_REPORT_OFFSET
      && power_report_q[`PWR_SOURCING_BIT]);

endmodule
`default_nettype wire

/* rtl/sticky_flag_bank.sv */
// bank of sticky flags, hardware set wins over write-one-to-clear
`timescale 1ns/100ps
`default_nettype none
module sticky_flag_bank #(
  parameter int W = 8,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] flags_q
);

  logic [W-1:0] flags_d;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // a set in the clearing cycle must not be lost
      always_comb begin
        flags_d[i] = set[i] | (flags_q[i] & ~clr[i]);
      end
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          flags_q[i] <= RESET_VAL[i];
        end else if (ce) begin
          flags_q[i] <= flags_d[i];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

/* rtl/tcpc_status_defs.svh */
// constants for the power and fault condition report registers
`ifndef TCPC_STATUS_DEFS_SVH
`define TCPC_STATUS_DEFS_SVH

// ----------------------------------------------------------------------
// register bus shape and offsets
// ----------------------------------------------------------------------
`define REG_ADDR_W 8
`define REG_DATA_W 8
`define PWR_REPORT_OFFSET 8'h1e
`define FLT_REPORT_OFFSET 8'h1f
`define UNMAPPED_READ 8'h00

// ----------------------------------------------------------------------
// power condition report fields and reset value
// ----------------------------------------------------------------------
`define PWR_DEBUG_BIT 7
`define PWR_INIT_BIT 6
`define PWR_RAISED_BIT 5
`define PWR_SOURCING_BIT 4
`define PWR_DETECT_BIT 3
`define PWR_BUS_PRESENT_BIT 2
`define PWR_CABLE_BIT 1
`define PWR_SINKING_BIT 0
`define PWR_RESET 8'h08

// ----------------------------------------------------------------------
// fault condition report fields and reset value
// ----------------------------------------------------------------------
`define FLT_REGS_RESET_BIT 7
`define FLT_FORCED_OFF_BIT 6
`define FLT_AUTO_DISCH_BIT 5
`define FLT_FORCED_DISCH_BIT 4
`define FLT_BUS_OC_BIT 3
`define FLT_BUS_OV_BIT 2
`define FLT_CABLE_OC_BIT 1
`define FLT_I2C_ERR_BIT 0
`define FLT_RESET 8'h80

`endif

/* rtl/tcpc_status_pkg.sv */
// types shared by the status register bank
`include "tcpc_status_defs.svh"
package tcpc_status_pkg;

  // register access from the management interface, same clock
  typedef struct packed {
    logic rd;
    logic wr;
    logic [`REG_ADDR_W-1:0] addr;
    logic [`REG_DATA_W-1:0] wdata;
  } reg_req_t;

  // status levels from on-chip logic, same clock
  typedef struct packed {
    logic debug_accessory_attached;
    logic init_running;
    logic sourcing_raised_voltage;
    logic sourcing_bus_power;
    logic bus_detect_enabled;
  } ctrl_status_t;

  // analog comparator levels, asynchronous to clk
  typedef struct packed {
    logic bus_power_present;
    logic cc1_cable_power;
    logic cc2_cable_power;
    logic bus_forced_off;
    logic auto_discharge_failed;
    logic forced_discharge_failed;
    logic bus_overcurrent;
    logic bus_overvoltage;
    logic cable_power_overcurrent;
  } analog_in_t;

endpackage

/* tb/port_power_fault_status_regs_tb_top.sv */
// self-checking bench for the power and fault report registers
`include "tcpc_status_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module port_power_fault_status_regs_tb_top;
  logic clk, resetn, ce, i2c_error, v;
  tcpc_status_pkg::reg_req_t reg_req;
  tcpc_status_pkg::ctrl_status_t ctrl;
  tcpc_status_pkg::analog_in_t analog;
  logic [7:0] rd_data_q, d;
  logic rd_valid_q;
  logic power_changed_q, fault_pending_q;
  logic [7:0] pwr_q, prev_exp;
  logic [7:0] pcase [6] = '{8'h08, 8'h80, 8'h4c, 8'h2a, 8'h39, 8'h1b};
  int n_errors = 0;
  int checks = 0;

  port_power_fault_status_regs i_dut (.clk(clk), .resetn(resetn),
    .ce(ce), .reg_req(reg_req), .ctrl(ctrl), .analog(analog),
    .i2c_error(i2c_error), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
    .power_report_q(pwr_q), .fault_report_q(),
    .power_changed_q(power_changed_q), .fault_pending_q(fault_pending_q));
  tcpm_host_model i_host (.clk(clk), .req(reg_req),
    .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    i_host.read_reg(a, d, v);
    check({7'h00, v}, 8'h01);
    check(d, exp);
  endtask

  // expectation built from the field layout, not from the design
  function automatic logic [7:0] pwr_exp(input logic [7:0] pc);
    return {pc[7], pc[6], pc[5] & pc[4], pc[4], pc[3], pc[2],
            pc[1] | pc[0], 1'b0};
  endfunction

  task automatic do_reset();
    resetn <= 1'b0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    // two sync flops plus margin before the first request
    repeat (4) @(posedge clk);
  endtask

  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    i2c_error = 1'b0;
    ctrl = 5'b00001;
    analog = '0;
    prev_exp = 8'h08;
    do_reset();
    rd_chk(`PWR_REPORT_OFFSET, 8'h08);
    rd_chk(`FLT_REPORT_OFFSET, 8'h80);
    check({7'h00, fault_pending_q}, 8'h01);
    i_host.write_reg(`FLT_REPORT_OFFSET, 8'h80);
    rd_chk(`FLT_REPORT_OFFSET, 8'h00);
    check({7'h00, fault_pending_q}, 8'h00);
    // ----------------------------------------------------------------
    // power report fields follow the status levels
    // ----------------------------------------------------------------
    foreach (pcase[i]) begin
      @(posedge clk);
      ctrl <= pcase[i][7:3];
      analog <= {pcase[i][2:0], 6'h00};
      // same-clock fields move first, so the change pulse tracks them
      @(posedge clk);
      #1;
      check({7'h00, power_changed_q},
        {7'h00, |((pwr_exp(pcase[i]) ^ prev_exp) & 8'hf8)});
      prev_exp = pwr_exp(pcase[i]);
      repeat (5) @(posedge clk);
      i_host.write_reg(`PWR_REPORT_OFFSET, 8'hff);
      rd_chk(`PWR_REPORT_OFFSET, pwr_exp(pcase[i]));
      rd_chk(`PWR_REPORT_OFFSET, pwr_exp(pcase[i]));
    end
    // ----------------------------------------------------------------
    // each fault source lands on its own bit and clears by write-one
    // ----------------------------------------------------------------
    @(posedge clk);
    analog <= '0;
    for (int k = 0; k < 7; k++) begin
      @(posedge clk);
      if (k == 0) i2c_error <= 1'b1;
      else analog <= {3'b000, 6'(1 << (k - 1))};
      repeat (2) @(posedge clk);
      i2c_error <= 1'b0;
      analog <= '0;
      repeat (5) @(posedge clk);
      rd_chk(`FLT_REPORT_OFFSET, 8'(1 << k));
      i_host.write_reg(`FLT_REPORT_OFFSET, 8'(1 << k));
      rd_chk(`FLT_REPORT_OFFSET, 8'h00);
    end
    // a fault still held high survives the clear
    @(posedge clk);
    analog.bus_overcurrent <= 1'b1;
    repeat (5) @(posedge clk);
    i_host.write_reg(`FLT_REPORT_OFFSET, 8'h08);
    rd_chk(`FLT_REPORT_OFFSET, 8'h08);
    @(posedge clk);
    analog.bus_overcurrent <= 1'b0;
    repeat (5) @(posedge clk);
    i_host.write_reg(`FLT_REPORT_OFFSET, 8'h08);
    rd_chk(`FLT_REPORT_OFFSET, 8'h00);
    // unmapped place reads zero and takes no write
    i_host.write_reg(8'h20, 8'hff);
    rd_chk(8'h20, `UNMAPPED_READ);
    rd_chk(`FLT_REPORT_OFFSET, 8'h00);
    // a low clock enable freezes the report until it returns
    @(posedge clk);
    ce <= 1'b0;
    ctrl <= 5'b10011;
    repeat (3) @(posedge clk);
    #1;
    check(pwr_q, 8'h18);
    @(posedge clk);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(pwr_q, 8'h98);
    // second reset in mid-run sets the reset flag again
    @(posedge clk);
    do_reset();
    rd_chk(`FLT_REPORT_OFFSET, 8'h80);
    check({7'h00, fault_pending_q}, 8'h01);
    rd_chk(`PWR_REPORT_OFFSET, 8'h98);
    wrap_up();
  end

  initial begin
    #2000000;
    n_errors++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
    wrap_up();
  end
endmodule
`default_nettype wire

/* tb/tcpm_host_model.sv */
// host-side register access model, one strobe per access
`timescale 1ns/100ps
`default_nettype none
module tcpm_host_model (
  input wire logic clk,
  output tcpc_status_pkg::reg_req_t req,
  input wire logic [7:0] rd_data_q,
  input wire logic rd_valid_q
);
  initial begin
    req = '0;
  end
  // the strobe stands one cycle; the answer is taken after the next edge
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                          output logic v);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    v = rd_valid_q;
    d = rd_data_q;
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] w);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= w;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
endmodule
`default_nettype wire
